// ==== logic/sfm_pkg.sv ====
/*
 * Shared constants and carrier types for the superframe marker and
 * D-channel timing block. Assumes a single 200 MHz system clock.
 */
package sfm_pkg;
    localparam int unsigned SFM_CLK_MHZ = 200;
    localparam int unsigned SFM_FRAMES_PER_SUPER = 96;
    localparam int unsigned SFM_FRAME_PERIOD_US = 125;
    localparam int unsigned SFM_FRAME_PERIOD_CYC = SFM_FRAME_PERIOD_US * SFM_CLK_MHZ;
    localparam logic [6:0] SFM_CNT_RESET = 7'h00;
    localparam logic [6:0] SFM_CNT_LAST = 7'h5f;
    localparam logic [3:0] SFM_DBITS_8 = 4'h8;
    localparam logic [3:0] SFM_DBITS_10 = 4'ha;
    localparam int unsigned SFM_SYNC_DEPTH = 2;

    // Pin inputs from the port side, already past synchronisers
    typedef struct packed {
        logic bit_clock;
        logic tx_frame_sync;
        logic rx_frame_sync;
        logic tx_superframe_marker;
        logic dchan_serial_in;
    } sfm_pins_in_t;

    // Operating mode straps
    typedef struct packed {
        logic long_frame;
        logic sync_master;
        logic marker_output;
        logic dchan_ten_bit;
    } sfm_mode_t;
endpackage

// ==== logic/sfm_sync.sv ====
/*
 * Two-flip-flop synchroniser bank for the port pins.
 * Assumes inputs are asynchronous to ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module sfm_sync #(
    parameter int unsigned WIDTH = 5
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
        end
    end

    assign sync_out = stage2;
endmodule // sfm_sync
`default_nettype wire

// ==== logic/sfm_port.sv ====
/*
 * Frame and superframe marker handling plus D-channel clocking for the
 * time-division serial port. Assumes the port bit clock is far slower
 * than ref_clk (at least four ref_clk cycles per phase).
 */
// What this block does
// - Short frame: marker sampled first falling edge
// - Long frame: marker sampled at sync rise
// - Output markers pulse once per 96 frames
// - Short frame marker one bit clock, next
// - Long frame marker: master rises with sync, slave at next fall
// - Master long frame: syncs rise after rising
// - Slave long frame: syncs sampled on falling
// - D-channel clock rises with port clock rise
// - D-channel output updated after clock rise
// - D-channel input captured on falling edge
`timescale 1ns/1ps
`default_nettype none
module sfm_port
    import sfm_pkg::*;
#(
    parameter int unsigned FRAME_PERIOD_CYC = sfm_pkg::SFM_FRAME_PERIOD_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Mode straps
    input wire sfm_pkg::sfm_mode_t mode,
    // Port pins in
    input wire logic port_bit_clock,
    input wire logic tx_frame_sync_in,
    input wire logic rx_frame_sync_in,
    input wire logic tx_superframe_marker_in,
    input wire logic dchan_serial_in,
    // Port pins out
    output logic tx_frame_sync,
    output logic rx_frame_sync,
    output logic tx_superframe_marker,
    output logic rx_superframe_marker,
    output logic marker_oe,
    output logic dchan_bit_clock,
    output logic dchan_serial_out,
    // D-channel user side
    input wire logic [9:0] dchan_tx_word,
    output logic [9:0] dchan_rx_word,
    output logic dchan_rx_valid,
    output logic [6:0] frame_count
);
    import sfm_pkg::*;

    initial begin
        if (FRAME_PERIOD_CYC < 16) begin
            $error("FRAME_PERIOD_CYC too small");
        end
    end

    ////////////////////////////////////////////////////////////////////
    sfm_pins_in_t pins;
    logic [4:0] pins_raw;
    logic [4:0] pins_sync;

    assign pins_raw = {port_bit_clock, tx_frame_sync_in, rx_frame_sync_in,
                       tx_superframe_marker_in, dchan_serial_in};
    assign pins = sfm_pins_in_t'(pins_sync);

    sfm_sync #(.WIDTH(5)) u_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .async_in(pins_raw),
        .sync_out(pins_sync)
    );

    ////////////////////////////////////////////////////////////////////
    // Edge history of the synchronised pins
    logic clk_prev, fsx_prev, fsr_prev;
    logic next_clk_prev, next_fsx_prev, next_fsr_prev;
    logic clk_rise, clk_fall;

    assign clk_rise = pins.bit_clock && !clk_prev;
    assign clk_fall = !pins.bit_clock && clk_prev;

    always_comb begin
        next_clk_prev = pins.bit_clock;
        next_fsx_prev = pins.tx_frame_sync;
        next_fsr_prev = pins.rx_frame_sync;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            clk_prev <= 1'b0;
            fsx_prev <= 1'b0;
            fsr_prev <= 1'b0;
        end else begin
            clk_prev <= next_clk_prev;
            fsx_prev <= next_fsx_prev;
            fsr_prev <= next_fsr_prev;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Frame sync timing: master counts out the frame period, slave samples the pins
    logic [31:0] period_cnt, next_period_cnt;
    logic fs_drive, next_fs_drive;
    logic fsx_seen, fsr_seen, next_fsx_seen, next_fsr_seen;
    logic tx_frame, rx_frame;
    logic tx_superframe_marker_pend, next_tx_superframe_marker_pend;
    logic tx_superframe_marker_hit;
    logic fsx_rise;

    always_comb begin
        next_period_cnt = period_cnt;
        next_fs_drive = fs_drive;
        next_fsx_seen = fsx_seen;
        next_fsr_seen = fsr_seen;
        tx_frame = 1'b0;
        rx_frame = 1'b0;
        if (mode.sync_master) begin
            // Period floor keeps frames at least the nominal apart
            if (period_cnt < FRAME_PERIOD_CYC - 1) begin
                next_period_cnt = period_cnt + 32'h1;
            end
            if (clk_rise) begin
                if (period_cnt >= FRAME_PERIOD_CYC - 1) begin
                    next_fs_drive = 1'b1;
                    next_period_cnt = 32'h0;
                    tx_frame = 1'b1;
                    rx_frame = 1'b1;
                end else begin
                    next_fs_drive = 1'b0;
                end
            end
        end else if (clk_fall) begin
            // Sampled high level on falling edge counts the frame once
            next_fsx_seen = pins.tx_frame_sync;
            next_fsr_seen = pins.rx_frame_sync;
            tx_frame = pins.tx_frame_sync && !fsx_seen;
            rx_frame = pins.rx_frame_sync && !fsr_seen;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            period_cnt <= 32'h0;
            fs_drive <= 1'b0;
            fsx_seen <= 1'b0;
            fsr_seen <= 1'b0;
        end else begin
            period_cnt <= next_period_cnt;
            fs_drive <= next_fs_drive;
            fsx_seen <= next_fsx_seen;
            fsr_seen <= next_fsr_seen;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Marker input sampling
    // Far end keeps the 96-frame spacing; we only realign on it
    always_comb begin
        next_tx_superframe_marker_pend = tx_superframe_marker_pend;
        tx_superframe_marker_hit = 1'b0;
        // Master sync is our own, so its rise is the frame strobe itself
        fsx_rise = mode.sync_master ? tx_frame : (pins.tx_frame_sync && !fsx_prev);
        if (!mode.marker_output) begin
            if (mode.long_frame) begin
                // Held from the sync rise until the frame is counted
                if (fsx_rise) begin
                    next_tx_superframe_marker_pend = pins.tx_superframe_marker;
                end
                if (tx_frame) begin
                    tx_superframe_marker_hit = fsx_rise ? pins.tx_superframe_marker : tx_superframe_marker_pend;
                    next_tx_superframe_marker_pend = 1'b0;
                end
            end else begin
                if (fsx_rise) begin
                    next_tx_superframe_marker_pend = 1'b1;
                end
                if (tx_superframe_marker_pend && clk_fall) begin
                    tx_superframe_marker_hit = pins.tx_superframe_marker;
                    next_tx_superframe_marker_pend = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            tx_superframe_marker_pend <= 1'b0;
        end else begin
            tx_superframe_marker_pend <= next_tx_superframe_marker_pend;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Superframe counters; short sync pulse alignment is left to the
    // marker pin, so an unmarked stream takes its first frame after reset as frame zero
    logic [6:0] tx_cnt, rx_cnt, next_tx_cnt, next_rx_cnt;

    always_comb begin
        next_tx_cnt = tx_cnt;
        next_rx_cnt = rx_cnt;
        if (tx_superframe_marker_hit) begin
            next_tx_cnt = SFM_CNT_RESET;
        end else if (tx_frame) begin
            next_tx_cnt = (tx_cnt == SFM_CNT_LAST) ? SFM_CNT_RESET
                          : tx_cnt + 7'h01;
        end
        if (rx_frame) begin
            next_rx_cnt = (rx_cnt == SFM_CNT_LAST) ? SFM_CNT_RESET
                          : rx_cnt + 7'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            tx_cnt <= SFM_CNT_LAST;
            rx_cnt <= SFM_CNT_LAST;
        end else begin
            tx_cnt <= next_tx_cnt;
            rx_cnt <= next_rx_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Marker outputs
    logic sfx_out, sfr_out, next_sfx_out, next_sfr_out;
    logic sfx_arm, sfr_arm, next_sfx_arm, next_sfr_arm;

    always_comb begin
        next_sfx_out = sfx_out;
        next_sfr_out = sfr_out;
        next_sfx_arm = sfx_arm;
        next_sfr_arm = sfr_arm;
        if (!mode.marker_output) begin
            next_sfx_out = 1'b0;
            next_sfr_out = 1'b0;
        end else if (mode.long_frame) begin
            // Follows its own sync level through the marked frame
            next_sfx_out = (tx_frame || (sfx_out && tx_frame_sync_level()))
                           && (next_tx_cnt == SFM_CNT_RESET);
            next_sfr_out = (rx_frame || (sfr_out && rx_frame_sync_level()))
                           && (next_rx_cnt == SFM_CNT_RESET);
        end else begin
            // Arm after the clear: a master frame starts on a clock rise
            if (clk_rise) begin
                next_sfx_out = sfx_arm;
                next_sfr_out = sfr_arm;
                next_sfx_arm = 1'b0;
                next_sfr_arm = 1'b0;
            end
            if (tx_frame && next_tx_cnt == SFM_CNT_RESET) begin
                next_sfx_arm = 1'b1;
            end
            if (rx_frame && next_rx_cnt == SFM_CNT_RESET) begin
                next_sfr_arm = 1'b1;
            end
        end
    end

    function automatic logic tx_frame_sync_level();
        return mode.sync_master ? fs_drive : pins.tx_frame_sync;
    endfunction

    function automatic logic rx_frame_sync_level();
        return mode.sync_master ? fs_drive : pins.rx_frame_sync;
    endfunction

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sfx_out <= 1'b0;
            sfr_out <= 1'b0;
            sfx_arm <= 1'b0;
            sfr_arm <= 1'b0;
        end else begin
            sfx_out <= next_sfx_out;
            sfr_out <= next_sfr_out;
            sfx_arm <= next_sfx_arm;
            sfr_arm <= next_sfr_arm;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // D-channel: clock follows the port clock inside the D-channel burst
    logic [3:0] dbit, next_dbit;
    logic dclk, next_dclk;
    logic dout, next_dout;
    logic [9:0] dsh, next_dsh, drx, next_drx;
    logic drx_valid, next_drx_valid;
    logic [3:0] dlen;

    assign dlen = mode.dchan_ten_bit ? SFM_DBITS_10 : SFM_DBITS_8;

    always_comb begin
        next_dbit = dbit;
        next_dclk = dclk;
        next_dout = dout;
        next_dsh = dsh;
        next_drx = drx;
        next_drx_valid = 1'b0;
        if (tx_frame) begin
            next_dbit = 4'h0;
        end else if (clk_rise && dbit < dlen) begin
            next_dclk = 1'b1;
            next_dout = dchan_tx_word[4'(dlen - dbit - 4'h1)];
        end else if (clk_fall && dclk) begin
            next_dclk = 1'b0;
            next_dsh = {dsh[8:0], pins.dchan_serial_in};
            next_dbit = dbit + 4'h1;
            if (dbit + 4'h1 == dlen) begin
                next_drx = {dsh[8:0], pins.dchan_serial_in};
                next_drx_valid = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            dbit <= SFM_DBITS_10;
            dclk <= 1'b0;
            dout <= 1'b0;
            dsh <= 10'h000;
            drx <= 10'h000;
            drx_valid <= 1'b0;
        end else begin
            dbit <= next_dbit;
            dclk <= next_dclk;
            dout <= next_dout;
            dsh <= next_dsh;
            drx <= next_drx;
            drx_valid <= next_drx_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////
    logic moe;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            moe <= 1'b0;
        end else begin
            moe <= mode.marker_output;
        end
    end

    assign tx_frame_sync = fs_drive;
    assign rx_frame_sync = fs_drive;
    assign tx_superframe_marker = sfx_out;
    assign rx_superframe_marker = sfr_out;
    assign marker_oe = moe;
    assign dchan_bit_clock = dclk;
    assign dchan_serial_out = dout;
    assign dchan_rx_word = drx;
    assign dchan_rx_valid = drx_valid;
    assign frame_count = tx_cnt;
endmodule // sfm_port
`default_nettype wire

// ==== test/sfm_port_assertions.sv ====
/* Port timing checker for sfm_port.
   Assumes a bit clock at least eight ref_clk cycles per phase. */
`timescale 1ns/1ps
`default_nettype none
module sfm_port_assertions
    import sfm_pkg::*;
#(
    parameter int unsigned FRAME_PERIOD_CYC = 64
) (
    // Watched ports
    input wire logic ref_clk,
    input wire logic nrst,
    input wire sfm_pkg::sfm_mode_t mode,
    input wire logic port_bit_clock,
    input wire logic tx_frame_sync,
    input wire logic tx_superframe_marker,
    input wire logic rx_superframe_marker,
    input wire logic marker_oe,
    input wire logic dchan_bit_clock,
    input wire logic [6:0] frame_count
);
default clocking cb @(posedge ref_clk); endclocking
default disable iff (!nrst);
int unsigned gap;
logic fs_q;
// Saturating gap counter, spans far longer than any frame
always_ff @(posedge ref_clk) begin
    fs_q <= tx_frame_sync;
    if (!nrst) gap <= FRAME_PERIOD_CYC;
    else if (tx_frame_sync && !fs_q) gap <= 1;
    else if (gap < 32'hffff) gap <= gap + 1;
end
sequence s_short_rise;
    !mode.long_frame && $rose(tx_superframe_marker);
endsequence
property p_cnt; frame_count <= SFM_CNT_LAST; endproperty
a_cnt: assert property (p_cnt) else $error("frame count out of range");
property p_rst; $rose(nrst) |-> frame_count == SFM_CNT_LAST && !marker_oe; endproperty
a_rst: assert property (p_rst) else $error("bad state after reset");
property p_off;
    !mode.marker_output |-> !marker_oe && !tx_superframe_marker && !rx_superframe_marker;
endproperty
a_off: assert property (p_off) else $error("marker driven as input");
property p_zero;
    $rose(tx_superframe_marker) || $rose(rx_superframe_marker) |-> frame_count == SFM_CNT_RESET;
endproperty
a_zero: assert property (p_zero) else $error("marker off count zero");
property p_width;
    s_short_rise |-> tx_superframe_marker [*8] ##[1:12] !tx_superframe_marker;
endproperty
a_width: assert property (p_width) else $error("short marker width wrong");
property p_start; s_short_rise |-> $past(port_bit_clock, 2); endproperty
a_start: assert property (p_start) else $error("marker not on bit clock");
property p_long;
    mode.long_frame && mode.sync_master && $rose(tx_superframe_marker)
        |-> tx_frame_sync && !$past(tx_frame_sync, 2);
endproperty
a_long: assert property (p_long) else $error("long marker apart from sync");
property p_msync; mode.sync_master && $rose(tx_frame_sync) |-> $past(port_bit_clock, 2); endproperty
a_msync: assert property (p_msync) else $error("sync not after bit rise");
property p_gap; mode.sync_master && $rose(tx_frame_sync) |-> gap >= FRAME_PERIOD_CYC; endproperty
a_gap: assert property (p_gap) else $error("frames too close");
property p_dclk; $rose(dchan_bit_clock) |-> $past(port_bit_clock, 2); endproperty
a_dclk: assert property (p_dclk) else $error("d clock rise unrelated");
endmodule // sfm_port_assertions
bind sfm_port sfm_port_assertions #(.FRAME_PERIOD_CYC(FRAME_PERIOD_CYC)) u_sfm_port_assertions (
    .ref_clk, .nrst, .mode, .port_bit_clock, .tx_frame_sync, .tx_superframe_marker,
    .rx_superframe_marker, .marker_oe, .dchan_bit_clock, .frame_count);
`default_nettype wire

// ==== test/sfm_far_end.sv ====
/* Behavioural system-side controller: bit clock, slave syncs, marker, D data.
   Assumes dlen of 8 or 10 and twelve bit clocks per frame. */
`timescale 1ns/1ps
`default_nettype none
module sfm_far_end #(
    parameter int MARK_AT = 5
) (
    // Control
    input wire logic nrst,
    input wire logic long_frame,
    input wire logic mark_en,
    input wire logic frame_start,
    input wire logic dchan_bit_clock,
    input wire logic [3:0] dlen,
    input wire logic [9:0] d_word,
    // Pins
    output logic port_bit_clock,
    output logic frame_sync,
    output logic marker,
    output logic marked,
    output logic dchan_serial_in
);
logic [3:0] b;
int f;
int idx;
logic [9:0] word;
initial begin
    port_bit_clock = 1'b0;
    dchan_serial_in = 1'b0;
    b = 4'h8;
    f = 0;
    idx = 10;
    word = 10'h000;
end
always #40 port_bit_clock = ~port_bit_clock;
// Held in the low part of a frame so no false sync edge at release
always @(posedge port_bit_clock or negedge nrst) begin
    if (!nrst) begin
        b <= 4'h8;
        f <= 0;
    end else begin
        b <= (b == 4'hb) ? 4'h0 : b + 4'h1;
        if (b == 4'hb) f <= f + 1;
    end
end
assign frame_sync = long_frame ? (b < 4'h8) : (b == 4'h0);
// Spans the sync rise and the first falling edge after it
assign marker = mark_en && (((b == 4'h0) && (f == MARK_AT)) || ((b == 4'hb) && (f == MARK_AT - 1)));
assign marked = mark_en && (f == MARK_AT);
always @(posedge frame_start) begin
    word = d_word;
    idx = 0;
end
// Bits change on the rise so they are steady at the fall; released line toggles
always @(posedge dchan_bit_clock) begin
    if (idx < int'(dlen)) begin
        dchan_serial_in <= word[int'(dlen) - 1 - idx];
        idx = idx + 1;
    end else dchan_serial_in <= ~dchan_serial_in;
end
endmodule // sfm_far_end
`default_nettype wire

// ==== test/testbench.sv ====
/* Self-checking bench for sfm_port in four mode phases.
   Assumes sfm_far_end and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
import sfm_pkg::*;
logic ref_clk, nrst, dq, seen;
sfm_mode_t mode;
logic [9:0] dchan_tx_word, d_word, rx_word, obits;
logic [9:0] exp_q[$];
int n_errors, check_count, exp_cnt, nv, nf;
wire logic bclk, pfs, pmark, pmarked, din, tfs, rfs, tsm, rsm, moe, dclk, dout, rxv;
wire logic [6:0] fcnt;
wire logic fs_seen = mode.sync_master ? tfs : pfs;
wire logic [3:0] dlen = mode.dchan_ten_bit ? SFM_DBITS_10 : SFM_DBITS_8;
wire logic [9:0] mask = ~(10'h3ff << dlen);
sfm_port #(.FRAME_PERIOD_CYC(192)) u_sfm_port (.ref_clk(ref_clk), .nrst(nrst), .mode(mode),
    .port_bit_clock(bclk), .tx_frame_sync_in(pfs), .rx_frame_sync_in(pfs),
    .tx_superframe_marker_in(pmark), .dchan_serial_in(din), .tx_frame_sync(tfs),
    .rx_frame_sync(rfs), .tx_superframe_marker(tsm), .rx_superframe_marker(rsm),
    .marker_oe(moe), .dchan_bit_clock(dclk), .dchan_serial_out(dout),
    .dchan_tx_word(dchan_tx_word), .dchan_rx_word(rx_word), .dchan_rx_valid(rxv),
    .frame_count(fcnt));
sfm_far_end u_sfm_far_end (.nrst(nrst), .long_frame(mode.long_frame),
    .mark_en(!mode.marker_output), .frame_start(fs_seen), .dchan_bit_clock(dclk),
    .dlen(dlen), .d_word(d_word), .port_bit_clock(bclk), .frame_sync(pfs),
    .marker(pmark), .marked(pmarked), .dchan_serial_in(din));
always #2.5 ref_clk = ~ref_clk;
task check(input logic [9:0] got, input logic [9:0] exp_v);
    check_count++;
    if (got !== exp_v) begin
        n_errors++;
        $display("wrong value at %0t: saw %h expected %h", $time, got, exp_v);
    end
endtask
task final_report;
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////////////
// Driver notes the word it sends at each frame start
always @(posedge fs_seen) if (nrst) begin
    exp_q.push_back(d_word & mask);
    #1 d_word = 10'($urandom);
end
// Watcher samples before this edge's updates land
always @(posedge ref_clk) begin
    if (nrst && dq && !dclk) obits = {obits[8:0], dout};
    if (nrst && rxv) begin
        exp_cnt = pmarked ? 0 : (exp_cnt + 1) % 96;
        check({3'h0, fcnt}, 10'(exp_cnt));
        check(rx_word & mask, exp_q.size() > 0 ? exp_q.pop_front() : 10'bx);
        check(obits & mask, dchan_tx_word & mask);
        obits = 10'h000;
        nv++;
        nf++;
    end
    dq = dclk;
end
always @(posedge tsm) begin
    if (seen) check(10'(nv), 10'h060);
    seen = 1'b1;
    nv = 0;
end
task phase(input logic [3:0] m, input int frames);
    @(posedge ref_clk);
    #1 nrst = 1'b0;
    mode = sfm_mode_t'(m);
    dchan_tx_word = 10'($urandom);
    exp_q.delete();
    seen = 1'b0;
    nv = 0;
    nf = 0;
    exp_cnt = 95;
    obits = 10'h000;
    repeat (5) @(posedge ref_clk);
    #1 nrst = 1'b1;
    for (int i = 0; i < frames * 500 && nf < frames; i++) @(posedge ref_clk);
    check(10'(nf), 10'(frames));
endtask
initial begin
    {ref_clk, nrst, dq, seen} = 4'h0;
    mode = sfm_mode_t'(4'h0);
    {dchan_tx_word, d_word, obits} = {10'h000, 10'h000, 10'h000};
    n_errors = 0;
    check_count = 0;
    exp_cnt = 95;
    nv = 0;
    nf = 0;
    void'($urandom(32'h2d39));
    phase(4'h0, 20);
    phase(4'h9, 20);
    phase(4'h6, 193);
    phase(4'hf, 193);
    final_report();
end
initial begin
    #480000;
    n_errors++;
    final_report();
end
endmodule // testbench
`default_nettype wire
